// >>> uprc_pkg.sv
// package: register map and field positions for usb pin and regulator control
package uprc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_REGULATOR_CONTROL = 8'h73;
  localparam logic [7:0] REG_TRANSCEIVER_CONFIG = 8'h74;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int XCR_PULLUP_BIT = 7;
  localparam int XCR_OVERRIDE_BIT = 0;
  localparam int VRC_ON_BIT = 0;
  localparam int VRC_TRICKLE_BIT = 1;
  localparam logic FIELD_RESET = 1'h0;
  localparam logic GPIO_EN_RESET = 1'h1;
  localparam logic DRIVE_ON = 1'h1;
  localparam int SYNC_DEPTH = 2;
  localparam int PIN_COUNT = 3;
  localparam int PIN_USB_MODE = 0;
  localparam int PIN_PORT_BIT0 = 1;
  localparam int PIN_PORT_BIT1 = 2;
endpackage

// >>> uprc_ctrl.sv
// usb pin override, pull-up and 3.3v regulator control registers
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module uprc_ctrl
  import uprc_pkg::*;
#(
  parameter int SYNC_STAGES = SYNC_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_usb_mode,
  input wire logic i_port1_bit0,
  input wire logic i_port1_bit1,
  input wire logic i_xcvr_dm_oe,
  input wire logic i_xcvr_dm,
  input wire logic i_xcvr_dp_oe,
  input wire logic i_xcvr_dp,
  output logic o_dm_oe,
  output logic o_dm,
  output logic o_dp_oe,
  output logic o_dp,
  output logic o_pullup_on,
  output logic o_pullup_to_reg,
  output logic o_reg_out_on,
  output logic o_port1_bit2_gpio_en,
  output logic o_reg_trickle
);
  localparam int LAST_STAGE = SYNC_STAGES - 1;

  // implemented register fields
  logic pullup_en_q;
  logic override_q;
  logic reg_on_q;
  logic trickle_q;

  // bus decode
  logic sel_xcr;
  logic sel_vrc;
  logic wr_xcr;
  logic wr_vrc;
  logic [DATA_W-1:0] rdata_d;

  // pin-side inputs before and after synchronisation
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_sync;
  logic forcing;

  // next values of the usb pin drive
  logic dm_oe_d;
  logic dm_d;
  logic dp_oe_d;
  logic dp_d;

  always_comb begin
    sel_xcr = 1'h0;
    sel_vrc = 1'h0;
    if (i_addr == REG_TRANSCEIVER_CONFIG) begin
      sel_xcr = 1'h1;
    end else if (i_addr == REG_REGULATOR_CONTROL) begin
      sel_vrc = 1'h1;
    end
  end

  assign wr_xcr = i_wr && sel_xcr;
  assign wr_vrc = i_wr && sel_vrc;

  // only the implemented fields are stored; reserved bits drop on write
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pullup_en_q <= FIELD_RESET;
    end else if (wr_xcr) begin
      pullup_en_q <= i_wdata[XCR_PULLUP_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      override_q <= FIELD_RESET;
    end else if (wr_xcr) begin
      override_q <= i_wdata[XCR_OVERRIDE_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      reg_on_q <= FIELD_RESET;
    end else if (wr_vrc) begin
      reg_on_q <= i_wdata[VRC_ON_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      trickle_q <= FIELD_RESET;
    end else if (wr_vrc) begin
      trickle_q <= i_wdata[VRC_TRICKLE_BIT];
    end
  end

  // unmapped addresses and reserved bits read as zero
  always_comb begin
    rdata_d = RESET_VALUE;
    if (!i_rd) begin
      rdata_d = RESET_VALUE;
    end else if (sel_xcr) begin
      rdata_d[XCR_PULLUP_BIT] = pullup_en_q;
      rdata_d[XCR_OVERRIDE_BIT] = override_q;
    end else if (sel_vrc) begin
      rdata_d[VRC_ON_BIT] = reg_on_q;
      rdata_d[VRC_TRICKLE_BIT] = trickle_q;
    end
  end

  // read data stands for exactly the one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_rdata <= RESET_VALUE;
    end else begin
      o_rdata <= rdata_d;
    end
  end

  assign pin_raw[PIN_USB_MODE] = i_usb_mode;
  assign pin_raw[PIN_PORT_BIT0] = i_port1_bit0;
  assign pin_raw[PIN_PORT_BIT1] = i_port1_bit1;

  // pin-side inputs come from outside the clock domain
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_sync
    logic [SYNC_STAGES-1:0] stage_q;
    always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
        stage_q <= '0;
      end else begin
        stage_q <= {stage_q[LAST_STAGE-1:0], pin_raw[g]};
      end
    end
    assign pin_sync[g] = stage_q[LAST_STAGE];
  end

  // override only takes the pins while they are in usb mode
  assign forcing = override_q && pin_sync[PIN_USB_MODE];

  // usb pins only; forcing drives D- from port bit1 and D+ from port bit0
  always_comb begin
    if (forcing) begin
      dm_oe_d = DRIVE_ON;
      dm_d = pin_sync[PIN_PORT_BIT1];
      dp_oe_d = DRIVE_ON;
      dp_d = pin_sync[PIN_PORT_BIT0];
    end else begin
      dm_oe_d = i_xcvr_dm_oe;
      dm_d = i_xcvr_dm;
      dp_oe_d = i_xcvr_dp_oe;
      dp_d = i_xcvr_dp;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_dm_oe <= FIELD_RESET;
      o_dm <= FIELD_RESET;
    end else begin
      o_dm_oe <= dm_oe_d;
      o_dm <= dm_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_dp_oe <= FIELD_RESET;
      o_dp <= FIELD_RESET;
    end else begin
      o_dp_oe <= dp_oe_d;
      o_dp <= dp_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_pullup_on <= FIELD_RESET;
    end else begin
      o_pullup_on <= pullup_en_q;
    end
  end

  // pull-up rail follows the regulator so D- never sees two supplies
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_pullup_to_reg <= FIELD_RESET;
    end else begin
      o_pullup_to_reg <= pullup_en_q && reg_on_q;
    end
  end

  // o_port1_bit2_gpio_en drops and trickle is masked in hardware while the regulator output is on
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_reg_out_on <= FIELD_RESET;
    end else begin
      o_reg_out_on <= reg_on_q;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_port1_bit2_gpio_en <= GPIO_EN_RESET;
    end else begin
      o_port1_bit2_gpio_en <= !reg_on_q;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_reg_trickle <= FIELD_RESET;
    end else begin
      o_reg_trickle <= trickle_q && !reg_on_q;
    end
  end
endmodule
`default_nettype wire

// >>> uprc_properties.sv
// checker: register bus and control output relations
`timescale 1ns/1ps
`default_nettype none
module uprc_properties (
  input wire logic i_mclk, i_nrst, i_wr, i_rd, o_pullup_on, o_reg_trickle,
  input wire logic o_pullup_to_reg, o_reg_out_on, o_port1_bit2_gpio_en,
  input wire logic [7:0] i_addr, i_wdata, o_rdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire wx = i_wr & (i_addr == 8'h74);
  wire wv = i_wr & (i_addr == 8'h73);
  wire tk = i_wdata[1] & ~i_wdata[0];
  property p_pu; wx |-> ##2 o_pullup_on == $past(i_wdata[7], 2); endproperty
  a_pu: assert property (p_pu) else $error("pu");
  property p_pr; o_pullup_on |-> o_pullup_to_reg == o_reg_out_on; endproperty
  a_pr: assert property (p_pr) else $error("pr");
  property p_on; wv |-> ##2 o_reg_out_on == $past(i_wdata[0], 2); endproperty
  a_on: assert property (p_on) else $error("on");
  property p_gp; o_port1_bit2_gpio_en != o_reg_out_on; endproperty
  a_gp: assert property (p_gp) else $error("gp");
  property p_tk; wv |-> ##2 o_reg_trickle == $past(tk, 2); endproperty
  a_tk: assert property (p_tk) else $error("tk");
  property p_um;
    i_rd && !(i_addr inside {8'h73, 8'h74}) |=> !o_rdata;
  endproperty
  a_um: assert property (p_um) else $error("um");
  property p_rs; i_rd |=> o_rdata[6:2] == 5'h00; endproperty
  a_rs: assert property (p_rs) else $error("rs");
  property p_id; !i_rd |=> o_rdata == 8'h00; endproperty
  a_id: assert property (p_id) else $error("id");
  c_x: cover property (wx);
  c_v: cover property (wv);
  c_t: cover property (o_reg_trickle);
endmodule
bind uprc_ctrl uprc_properties u_chk (.*);
`default_nettype wire

// >>> uprc_host.sv
// far side: host pull-downs and device drive resolve the line levels
`timescale 1ns/1ps
`default_nettype none
module uprc_host (
  input wire logic o_dm_oe, o_dm, o_dp_oe, o_dp, o_pullup_on,
  output logic dm_lvl, dp_lvl
);
  assign dm_lvl = o_dm_oe ? o_dm : o_pullup_on;
  assign dp_lvl = o_dp_oe & o_dp;
endmodule
`default_nettype wire

// >>> tb_usb_pin_and_regulator_control.sv
// testbench: register traffic, pin override and regulator outputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_usb_pin_and_regulator_control;
  logic i_mclk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_usb_mode = 0, fc;
  logic i_port1_bit0 = 0, i_port1_bit1 = 0, i_xcvr_dm_oe = 0, i_xcvr_dm = 0;
  logic i_xcvr_dp_oe = 0, i_xcvr_dp = 0, o_dm_oe, o_dm, o_dp_oe, o_dp;
  logic o_pullup_on, o_pullup_to_reg, o_reg_out_on, o_reg_trickle;
  logic o_port1_bit2_gpio_en, dm_lvl, dp_lvl, lv;
  logic [1:0] e2;
  logic [3:0] ctl;
  logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, m73 = 0, m74 = 0;
  logic [15:0] r = 16'hCE5E;
  int miscompares = 0, n_tests = 0;
  uprc_ctrl dut (.*);
  uprc_host host (.*);
  assign ctl = {o_pullup_on, o_reg_out_on, o_port1_bit2_gpio_en, o_reg_trickle};
  initial forever #2.5 i_mclk = ~i_mclk;
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task print_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // write, read back, then let the pin synchronisers settle
  task acc(input logic [7:0] ad, input logic [7:0] dd);
    i_addr <= ad;
    i_wdata <= dd;
    i_wr <= 1;
    if (ad == 8'h73) m73 = dd & 8'h03;
    if (ad == 8'h74) m74 = dd & 8'h81;
    @(posedge i_mclk);
    i_wr <= 0;
    i_rd <= 1;
    @(posedge i_mclk);
    i_rd <= 0;
    #1 `CHK(o_rdata, ad == 8'h73 ? m73 : ad == 8'h74 ? m74 : 8'h00)
    repeat (5) @(posedge i_mclk);
    #1 fc = m74[0] & i_usb_mode;
    `CHK(o_pullup_on, m74[7])
    `CHK(o_pullup_to_reg & o_pullup_on, m73[0] & m74[7])
    e2 = fc ? {1'h1, i_port1_bit1} : {i_xcvr_dm_oe, i_xcvr_dm};
    `CHK({o_dm_oe, o_dm}, e2)
    e2 = fc ? {1'h1, i_port1_bit0} : {i_xcvr_dp_oe, i_xcvr_dp};
    `CHK({o_dp_oe, o_dp}, e2)
    lv = i_xcvr_dm_oe ? i_xcvr_dm : m74[7];
    `CHK(dm_lvl, fc ? i_port1_bit1 : lv)
    `CHK(dp_lvl, fc ? i_port1_bit0 : i_xcvr_dp_oe & i_xcvr_dp)
    `CHK({o_reg_out_on, o_port1_bit2_gpio_en}, {m73[0], ~m73[0]})
    `CHK(o_reg_trickle, m73[1] & ~m73[0])
    @(posedge i_mclk);
  endtask
  initial begin
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1;
    @(posedge i_mclk);
    #1 `CHK(ctl, 4'h2)
    @(posedge i_mclk);
    acc(8'h75, 8'hFF);
    acc(8'h74, 8'hFF);
    acc(8'h73, 8'hFF);
    acc(8'h73, 8'h02);
    $display("corner cases done");
    repeat (40) begin
      r = nx(r);
      {i_usb_mode, i_port1_bit0, i_port1_bit1, i_xcvr_dm_oe, i_xcvr_dm,
        i_xcvr_dp_oe, i_xcvr_dp} <= r[14:8];
      acc(8'h72 + r[1:0], r[15:8] ^ r[7:0]);
    end
    $display("random traffic done");
    i_nrst <= 0;
    m73 = 8'h00;
    m74 = 8'h00;
    repeat (2) @(posedge i_mclk);
    #1 `CHK(ctl, 4'h2)
    @(posedge i_mclk);
    i_nrst <= 1;
    @(posedge i_mclk);
    acc(8'h75, 8'h00);
    $display("mid-run reset done");
    print_verdict;
  end
  initial begin
    #5000;
    miscompares++;
    print_verdict;
  end
endmodule
`default_nettype wire
